//--- hw/dausc_top.v
// status word and arithmetic control of the data arithmetic unit
//
// Local design decisions: the strobed register port and the placing of the registers.
`timescale 1ns/100ps
`include "dausc_regs.vh"

// Notes on behaviour
// - status bit 9 is accumulator one overflow, bit 4 accumulator zero
// - status bits 8:5 and 3:0 mirror guard bits 35:32 of each accumulator
// - negative flag set when result bit 35 is one
// - equal flag set when all 36 result bits are zero
// - logical overflow flag raised on logical overflow
// - mathematical overflow flag raised on arithmetic overflow
// - both arithmetic and bit-manipulation operations update the flags
// - input register write resets generator outside isr unless bit is one
// - squaring bit makes high y loads also load x
// - clear-inhibit bits stop low-half clearing of y, acc one, acc zero
// - saturation bits disable saturation on overflow per accumulator
// - alignment field scales product: none, /4, x4, x2
// - control holds nine bits; bits 15:9 read zero
// - control register clears to zero at reset
module dausc_top (
  input wire clk, // core clock, 40 MHz
  input wire sys_rst, // synchronous reset, high
  input wire [2:0] regAddr, // register address
  input wire [15:0] regWrData, // register write data
  input wire regWr, // register write strobe
  input wire regRd, // register read strobe
  output reg [15:0] regRdData, // read data, cycle after strobe
  input wire dauFlagWr, // arithmetic op updates flags
  input wire [35:0] dauResult, // arithmetic tested result
  input wire dauLlv, // arithmetic logical overflow
  input wire dauLmv, // arithmetic math overflow
  input wire bmuFlagWr, // bit-manipulation op updates flags
  input wire [35:0] bmuResult, // bit-manipulation result
  input wire bmuLlv, // bit-manipulation logical overflow
  input wire bmuLmv, // bit-manipulation math overflow
  input wire [36:0] sum, // true arithmetic result
  input wire a0SumLd, // load sum into acc zero
  input wire a1SumLd, // load sum into acc one
  input wire a0ProdLd, // move product into acc zero
  input wire a1ProdLd, // move product into acc one
  input wire a0HiLd, // load acc zero high half
  input wire a1HiLd, // load acc one high half
  input wire [15:0] hiData, // high-half data for accumulators
  input wire yHiLd, // load y high half
  input wire yLoLd, // load y low half
  input wire [15:0] yData, // y load data
  input wire xLd, // load x
  input wire [15:0] xData, // x load data
  input wire piWr, // write of pseudorandom input register
  input wire inIsr, // interrupt service in progress
  input wire psgStep, // advance pseudorandom generator
  output wire [35:0] acc0, // accumulator zero
  output wire [35:0] acc1, // accumulator one
  output reg [15:0] xReg, // first operand register
  output reg [31:0] yReg, // second operand register
  output reg [31:0] prod, // product register
  output reg [15:0] psgOut, // pseudorandom generator state
  output wire irq // level interrupt
);

  // ****************************************
  // register decode
  // ****************************************
  wire wrStatus;
  wire wrCtrl;
  wire wrMask;
  wire rdIrq;
  assign wrStatus = regWr & (regAddr == `DAUSC_OFS_STATUS);
  assign wrCtrl = regWr & (regAddr == `DAUSC_OFS_CTRL);
  assign wrMask = regWr & (regAddr == `DAUSC_OFS_IRQMASK);
  assign rdIrq = regRd & (regAddr == `DAUSC_OFS_IRQSTAT);

  // ****************************************
  // control register
  // ****************************************
  reg [8:0] ctrl;
  wire genRstOff;
  wire squareOn;
  wire clrInhY;
  wire clrInhA1;
  wire clrInhA0;
  wire satDisA1;
  wire satDisA0;
  wire [1:0] align;

  always @(posedge clk) begin
    if (sys_rst) begin
      ctrl <= `DAUSC_CT_RESET;
    end else if (wrCtrl) begin
      ctrl <= regWrData[8:0];
    end
  end

  assign genRstOff = ctrl[`DAUSC_CT_GENRST];
  assign squareOn = ctrl[`DAUSC_CT_SQUARE];
  assign clrInhY = ctrl[`DAUSC_CT_CLRY];
  assign clrInhA1 = ctrl[`DAUSC_CT_CLRA1];
  assign clrInhA0 = ctrl[`DAUSC_CT_CLRA0];
  assign satDisA1 = ctrl[`DAUSC_CT_SATA1];
  assign satDisA0 = ctrl[`DAUSC_CT_SATA0];
  assign align = ctrl[`DAUSC_CT_ALIGN_HI:`DAUSC_CT_ALIGN_LO];

  // ****************************************
  // condition flags
  // ****************************************
  wire [3:0] dauFlags;
  wire [3:0] bmuFlags;
  reg [3:0] condFlags;

  dausc_flags uDauFlags (
    .result(dauResult),
    .logical_overflow_flag(dauLlv),
    .math_overflow_flag(dauLmv),
    .flags(dauFlags)
  );

  dausc_flags uBmuFlags (
    .result(bmuResult),
    .logical_overflow_flag(bmuLlv),
    .math_overflow_flag(bmuLmv),
    .flags(bmuFlags)
  );

  // the core issues one flag-setting op per cycle; if both
  // strobes ever meet, the arithmetic unit wins
  always @(posedge clk) begin
    if (sys_rst) begin
      condFlags <= 4'h0;
    end else if (dauFlagWr) begin
      condFlags <= dauFlags;
    end else if (bmuFlagWr) begin
      condFlags <= bmuFlags;
    end else if (wrStatus) begin
      condFlags <= regWrData[15:12];
    end
  end

  // ****************************************
  // accumulators
  // ****************************************
  wire a0Ovf;
  wire a1Ovf;
  wire a0OvfEv;
  wire a1OvfEv;

  dausc_acc uAcc0 (
    .clk(clk),
    .sys_rst(sys_rst),
    .sumLd(a0SumLd),
    .sum(sum),
    .prodLd(a0ProdLd),
    .prod(prod),
    .align(align),
    .hiLd(a0HiLd),
    .hiData(hiData),
    .clrInh(clrInhA0),
    .satDis(satDisA0),
    .swWr(wrStatus),
    .swData(regWrData[4:0]),
    .acc(acc0),
    .ovf(a0Ovf),
    .ovfEv(a0OvfEv)
  );

  dausc_acc uAcc1 (
    .clk(clk),
    .sys_rst(sys_rst),
    .sumLd(a1SumLd),
    .sum(sum),
    .prodLd(a1ProdLd),
    .prod(prod),
    .align(align),
    .hiLd(a1HiLd),
    .hiData(hiData),
    .clrInh(clrInhA1),
    .satDis(satDisA1),
    .swWr(wrStatus),
    .swData(regWrData[9:5]),
    .acc(acc1),
    .ovf(a1Ovf),
    .ovfEv(a1OvfEv)
  );

  // ****************************************
  // status word
  // ****************************************
  wire [15:0] statusWord;
  assign statusWord = {condFlags, `DAUSC_ST_DC,
    a1Ovf, acc1[35:32],
    a0Ovf, acc0[35:32]};

  // ****************************************
  // operand registers and product
  // ****************************************
  always @(posedge clk) begin
    if (sys_rst) begin
      xReg <= 16'h0;
      yReg <= 32'h0;
      prod <= 32'h0;
    end else begin
      prod <= $signed(xReg) * $signed(yReg[31:16]);
      if (yHiLd) begin
        yReg[31:16] <= yData;
        if (~clrInhY) begin
          yReg[15:0] <= 16'h0;
        end
      end else if (yLoLd) begin
        yReg[15:0] <= yData;
      end
      if (yHiLd & squareOn) begin
        xReg <= yData;
      end else if (xLd) begin
        xReg <= xData;
      end
    end
  end

  // ****************************************
  // pseudorandom generator
  // ****************************************
  wire psgRst;
  wire psgFb;
  assign psgRst = piWr & ~genRstOff & ~inIsr;
  assign psgFb = psgOut[15] ^ psgOut[14] ^ psgOut[12] ^ psgOut[3];

  always @(posedge clk) begin
    if (sys_rst) begin
      psgOut <= `DAUSC_PSG_SEED;
    end else if (psgRst) begin
      psgOut <= `DAUSC_PSG_SEED;
    end else if (psgStep) begin
      psgOut <= {psgOut[14:0], psgFb};
    end
  end

  // ****************************************
  // interrupts
  // ****************************************
  reg [3:0] irqStat;
  reg [3:0] irqMask;
  reg lmvPrev;
  wire [3:0] irqEv;

  assign irqEv = {psgRst, condFlags[0] & ~lmvPrev, a1OvfEv, a0OvfEv};

  // a read clears the sticky bits, but an event in that same
  // cycle sets its bit again so nothing is lost
  always @(posedge clk) begin
    if (sys_rst) begin
      irqStat <= `DAUSC_IRQ_RESET;
      irqMask <= `DAUSC_IRQ_RESET;
      lmvPrev <= 1'b0;
    end else begin
      lmvPrev <= condFlags[0];
      irqStat <= (rdIrq ? 4'h0 : irqStat) | irqEv;
      if (wrMask) begin
        irqMask <= regWrData[3:0];
      end
    end
  end

  assign irq = |(irqStat & irqMask);

  // ****************************************
  // read port
  // ****************************************
  always @(posedge clk) begin
    if (sys_rst) begin
      regRdData <= 16'h0;
    end else if (regRd) begin
      case (regAddr)
        `DAUSC_OFS_STATUS: regRdData <= statusWord;
        `DAUSC_OFS_CTRL: regRdData <= {7'h00, ctrl};
        `DAUSC_OFS_IRQSTAT: regRdData <= {12'h000, irqStat};
        `DAUSC_OFS_IRQMASK: regRdData <= {12'h000, irqMask};
        `DAUSC_OFS_PSG: regRdData <= psgOut;
        default: regRdData <= 16'h0;
      endcase
    end else begin
      regRdData <= 16'h0;
    end
  end

endmodule

//--- hw/dausc_regs.vh
// register offsets, field positions and reset values of the dau status block
`ifndef DAUSC_REGS_VH
`define DAUSC_REGS_VH

// ****************************************
// register offsets
// ****************************************
`define DAUSC_OFS_STATUS 3'h0
`define DAUSC_OFS_CTRL 3'h1
`define DAUSC_OFS_IRQSTAT 3'h2
`define DAUSC_OFS_IRQMASK 3'h3
`define DAUSC_OFS_PSG 3'h4

// ****************************************
// status word fields
// ****************************************
`define DAUSC_ST_NEG 15
`define DAUSC_ST_EQ 14
`define DAUSC_ST_LLV 13
`define DAUSC_ST_LMV 12
`define DAUSC_ST_A1V 9
`define DAUSC_ST_A1G_HI 8
`define DAUSC_ST_A1G_LO 5
`define DAUSC_ST_A0V 4
`define DAUSC_ST_A0G_HI 3
`define DAUSC_ST_A0G_LO 0
`define DAUSC_ST_DC 2'h0

// ****************************************
// control register fields
// ****************************************
`define DAUSC_CT_GENRST 8
`define DAUSC_CT_SQUARE 7
`define DAUSC_CT_CLRY 6
`define DAUSC_CT_CLRA1 5
`define DAUSC_CT_CLRA0 4
`define DAUSC_CT_SATA1 3
`define DAUSC_CT_SATA0 2
`define DAUSC_CT_ALIGN_HI 1
`define DAUSC_CT_ALIGN_LO 0
`define DAUSC_CT_RESET 9'h000

// ****************************************
// alignment codes and interrupt events
// ****************************************
`define DAUSC_AL_NONE 2'h0
`define DAUSC_AL_DIV4 2'h1
`define DAUSC_AL_MUL4 2'h2
`define DAUSC_AL_MUL2 2'h3
`define DAUSC_EV_A0OVF 0
`define DAUSC_EV_A1OVF 1
`define DAUSC_EV_LMV 2
`define DAUSC_EV_PSGRST 3
`define DAUSC_IRQ_RESET 4'h0
`define DAUSC_PSG_SEED 16'h0001

`endif

//--- hw/dausc_flags.v
// condition flag evaluation of one tested result
`timescale 1ns/100ps
module dausc_flags (
  input wire [35:0] result, // tested 36-bit result
  input wire logical_overflow_flag, // logical overflow of the operation
  input wire math_overflow_flag, // mathematical overflow of the operation
  output reg [3:0] flags // neg, eq, llv, lmv
);

  always @* begin
    flags[3] = result[35];
    flags[2] = (result == 36'h0);
    flags[1] = logical_overflow_flag;
    flags[0] = math_overflow_flag;
  end

endmodule

//--- hw/dausc_acc.v
// one accumulator with alignment, saturation and low-half clearing
`timescale 1ns/100ps
`include "dausc_regs.vh"
module dausc_acc (
  input wire clk, // core clock
  input wire sys_rst, // synchronous reset, high
  input wire sumLd, // load arithmetic result
  input wire [36:0] sum, // true result, one bit wider
  input wire prodLd, // load product through aligner
  input wire [31:0] prod, // product register value
  input wire [1:0] align, // alignment code
  input wire hiLd, // load high half
  input wire [15:0] hiData, // high-half data
  input wire clrInh, // inhibit low-half clearing
  input wire satDis, // disable saturation
  input wire swWr, // software write of guard and v
  input wire [4:0] swData, // {v, guard[3:0]}
  output reg [35:0] acc, // accumulator value
  output reg ovf, // overflow bit
  output reg ovfEv // one-cycle overflow event
);

  reg [35:0] pe;
  reg [35:0] pa;
  reg [36:0] t;
  wire ovfNow;

  always @* begin
    pe = {{4{prod[31]}}, prod};
    case (align)
      `DAUSC_AL_NONE: pa = pe;
      `DAUSC_AL_DIV4: pa = {{2{pe[35]}}, pe[35:2]};
      `DAUSC_AL_MUL4: pa = {pe[33:0], 2'b00};
      `DAUSC_AL_MUL2: pa = {pe[34:0], 1'b0};
      default: pa = pe;
    endcase
    t = sumLd ? sum : {pa[35], pa};
  end

  // overflow means the value left the 32-bit range
  assign ovfNow = ~((&t[36:31]) | ~(|t[36:31]));

  always @(posedge clk) begin
    if (sys_rst) begin
      acc <= 36'h0;
      ovf <= 1'b0;
      ovfEv <= 1'b0;
    end else begin
      ovfEv <= 1'b0;
      if (sumLd | prodLd) begin
        ovf <= ovfNow;
        ovfEv <= ovfNow;
        if (ovfNow & ~satDis) begin
          acc <= t[36] ? 36'hf80000000 : 36'h07fffffff;
        end else begin
          acc <= t[35:0];
        end
      end else if (hiLd) begin
        acc[35:16] <= {{4{hiData[15]}}, hiData};
        if (~clrInh) begin
          acc[15:0] <= 16'h0;
        end
      end else if (swWr) begin
        acc[35:32] <= swData[3:0];
        ovf <= swData[4];
      end
    end
  end

endmodule

//--- bench/dausc_sva.sv
// assertion checker for the dau status and control ports
`timescale 1ns/100ps
module dausc_sva (
  input wire clk, sys_rst, regWr, regRd, dauFlagWr, bmuFlagWr, // strobes
  input wire bmuLlv, bmuLmv, a0SumLd, a1SumLd, a1ProdLd, yHiLd, // loads
  input wire piWr, inIsr, // generator control
  input wire [2:0] regAddr, // register index
  input wire [15:0] regWrData, regRdData, yData, xReg, psgOut, // words
  input wire [35:0] dauResult, acc0, acc1, // wide values
  input wire [36:0] sum, // true result
  input wire [31:0] prod, yReg // operand and product
);
  reg [8:0] ctl; // shadow of the control register
  wire rdSt = regRd && regAddr == 3'h0;
  wire idle = !dauFlagWr && !bmuFlagWr && !regWr;
  wire [1:0] dauNe = {dauResult[35], dauResult == 36'h0};
  wire [1:0] bmuOv = {bmuLlv, bmuLmv};
  wire [7:0] guards = {acc1[35:32], acc0[35:32]};
  wire [35:0] prodDiv4 = {{6{prod[31]}}, prod[31:2]};
  wire [35:0] satVal = sum[36] ? 36'hf80000000 : 36'h07fffffff;
  wire sumOvf = |sum[36:31] && !(&sum[36:31]);
  always @(posedge clk)
    if (sys_rst)
      ctl <= 9'h000;
    else if (regWr && regAddr == 3'h1)
      ctl <= regWrData[8:0];
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_then_read;
    idle ##1 rdSt && idle;
  endsequence
  property p_ctl_upper;
    $past(regRd) && $past(regAddr) == 3'h1 |-> regRdData[15:9] == 7'h00;
  endproperty
  a_ctl_upper: assert property (p_ctl_upper)
    else $error("control read shows upper bits");
  property p_dc;
    $past(rdSt) |-> regRdData[11:10] == 2'h0;
  endproperty
  a_dc: assert property (p_dc)
    else $error("status bits 11:10 not stable zero");
  property p_guard;
    $past(rdSt) |-> {regRdData[8:5], regRdData[3:0]} == $past(guards);
  endproperty
  a_guard: assert property (p_guard)
    else $error("guard fields differ from accumulators");
  property p_neg_eq;
    dauFlagWr ##1 s_then_read |=> regRdData[15:14] == $past(dauNe, 3);
  endproperty
  a_neg_eq: assert property (p_neg_eq)
    else $error("negative or equal flag wrong");
  property p_bmu;
    bmuFlagWr && !dauFlagWr ##1 s_then_read |=>
      regRdData[13:12] == $past(bmuOv, 3);
  endproperty
  a_bmu: assert property (p_bmu)
    else $error("overflow flags not set by bit operation");
  property p_sq;
    yHiLd && ctl[7] |=> xReg == $past(yData);
  endproperty
  a_sq: assert property (p_sq)
    else $error("squaring load missed x");
  property p_yclr;
    yHiLd && !ctl[6] |=> yReg == {$past(yData), 16'h0000};
  endproperty
  a_yclr: assert property (p_yclr)
    else $error("low half of y not cleared");
  property p_psg;
    piWr && !ctl[8] && !inIsr |=> psgOut == 16'h0001;
  endproperty
  a_psg: assert property (p_psg)
    else $error("generator not reset by input write");
  property p_sat;
    a0SumLd && !ctl[2] && sumOvf |=> acc0 == $past(satVal);
  endproperty
  a_sat: assert property (p_sat)
    else $error("saturation value wrong");
  property p_div4;
    a1ProdLd && !a1SumLd && ctl[1:0] == 2'h1 |=> acc1 == $past(prodDiv4);
  endproperty
  a_div4: assert property (p_div4)
    else $error("divide by four alignment wrong");
  c_rd: cover property (rdSt);
  c_ovf: cover property (a0SumLd && sumOvf);
  c_pi: cover property (piWr && !inIsr);
endmodule

//--- bench/dausc_seq.sv
// sequencer model that drives the datapath side of the block
`timescale 1ns/100ps
module dausc_seq (
  input wire clk, // core clock
  output logic dauFlagWr, bmuFlagWr, dauLlv, dauLmv, bmuLlv, bmuLmv, // flags
  output logic a0SumLd, a1SumLd, a0ProdLd, a1ProdLd, a0HiLd, a1HiLd, // loads
  output logic yHiLd, yLoLd, xLd, piWr, inIsr, psgStep, // strobes
  output logic [35:0] dauResult, bmuResult, // tested results
  output logic [36:0] sum, // true result
  output logic [15:0] hiData, yData, xData // load data
);
  task idle;
    {dauFlagWr, bmuFlagWr, a0SumLd, a1SumLd, a0ProdLd, a1ProdLd} <= 6'h00;
    {yHiLd, yLoLd, xLd, piWr, psgStep, a0HiLd, a1HiLd} <= 7'h00;
  endtask
  // stale sum and tested results are inverted so nothing relies on them being held; load data keeps its value
  task fin;
    @(posedge clk);
    idle;
    sum <= ~sum;
    dauResult <= ~dauResult;
    bmuResult <= ~bmuResult;
  endtask
  initial begin
    {dauLlv, dauLmv, bmuLlv, bmuLmv, inIsr} = 5'h00;
    {dauResult, bmuResult, sum, hiData, yData, xData} = '0;
    idle;
  end
  task flagOp(input b, input [35:0] r, input lv, input mv);
    @(posedge clk);
    {dauFlagWr, bmuFlagWr} <= {!b, b};
    {dauResult, bmuResult} <= {r, r};
    {dauLlv, bmuLlv, dauLmv, bmuLmv} <= {lv, lv, mv, mv};
    fin;
  endtask
  task sumLoad(input one, input [36:0] s);
    @(posedge clk);
    {a0SumLd, a1SumLd} <= {!one, one};
    sum <= s;
    fin;
  endtask
  task hiLoad(input one, input [15:0] d);
    @(posedge clk);
    {a0HiLd, a1HiLd} <= {!one, one};
    hiData <= d;
    fin;
  endtask
  task prodLoad(input one);
    @(posedge clk);
    {a0ProdLd, a1ProdLd} <= {!one, one};
    fin;
  endtask
  task load(input [2:0] k, input [15:0] d);
    @(posedge clk);
    {xLd, yHiLd, yLoLd} <= k;
    {xData, yData} <= {d, d};
    fin;
  endtask
  task pseudorandom_generator(input w, input isr);
    @(posedge clk);
    {piWr, psgStep} <= {w, !w};
    inIsr <= isr;
    fin;
  endtask
endmodule

//--- bench/dausc_top_bench.sv
// self-checking bench of the dau status and control block
`timescale 1ns/100ps
`define CHK(a, e) begin \
  compares++; \
  if ((a) !== (e)) begin \
    errorCnt++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (e)); \
  end \
end
module dausc_top_bench;
  logic clk, sys_rst, regWr, regRd, irq;
  logic [2:0] regAddr;
  logic [15:0] regWrData, regRdData, xReg, psgOut, hiData, yData, xData;
  logic dauFlagWr, bmuFlagWr, dauLlv, dauLmv, bmuLlv, bmuLmv;
  logic a0SumLd, a1SumLd, a0ProdLd, a1ProdLd, a0HiLd, a1HiLd;
  logic yHiLd, yLoLd, xLd, piWr, inIsr, psgStep;
  logic [35:0] dauResult, bmuResult, acc0, acc1;
  logic [36:0] sum;
  logic [31:0] yReg, prod;
  logic [35:0] alExp [4] = '{36'h80, 36'h20, 36'h200, 36'h100};
  int errorCnt = 0;
  int compares = 0;
  dausc_top i_dausc_top (
    .clk(clk), .sys_rst(sys_rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .dauFlagWr(dauFlagWr), .dauResult(dauResult),
    .dauLlv(dauLlv), .dauLmv(dauLmv), .bmuFlagWr(bmuFlagWr),
    .bmuResult(bmuResult), .bmuLlv(bmuLlv), .bmuLmv(bmuLmv), .sum(sum),
    .a0SumLd(a0SumLd), .a1SumLd(a1SumLd), .a0ProdLd(a0ProdLd),
    .a1ProdLd(a1ProdLd), .a0HiLd(a0HiLd), .a1HiLd(a1HiLd),
    .hiData(hiData), .yHiLd(yHiLd), .yLoLd(yLoLd), .yData(yData),
    .xLd(xLd), .xData(xData), .piWr(piWr), .inIsr(inIsr),
    .psgStep(psgStep), .acc0(acc0), .acc1(acc1), .xReg(xReg),
    .yReg(yReg), .prod(prod), .psgOut(psgOut), .irq(irq)
  );
  dausc_seq i_dausc_seq (
    .clk(clk), .dauFlagWr(dauFlagWr), .bmuFlagWr(bmuFlagWr),
    .dauLlv(dauLlv), .dauLmv(dauLmv), .bmuLlv(bmuLlv), .bmuLmv(bmuLmv),
    .a0SumLd(a0SumLd), .a1SumLd(a1SumLd), .a0ProdLd(a0ProdLd),
    .a1ProdLd(a1ProdLd), .a0HiLd(a0HiLd), .a1HiLd(a1HiLd),
    .yHiLd(yHiLd), .yLoLd(yLoLd), .xLd(xLd), .piWr(piWr),
    .inIsr(inIsr), .psgStep(psgStep), .dauResult(dauResult),
    .bmuResult(bmuResult), .sum(sum), .hiData(hiData), .yData(yData),
    .xData(xData)
  );
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task wr(input [2:0] a, input [15:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task rd(input [2:0] a, input [15:0] e);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1 `CHK(regRdData, e)
  endtask
  task testDone;
    $display("compares=%0d errors=%0d", compares, errorCnt);
    if (errorCnt == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // whole run is under two thousand cycles
  initial begin
    #100000;
    errorCnt++;
    testDone;
  end
  initial begin
    {regWr, regRd, regAddr, regWrData} = '0;
    sys_rst = 1'b1;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    rd(3'h1, 16'h0000);
    rd(3'h4, 16'h0001);
    rd(3'h0, 16'h0000);
    rd(3'h5, 16'h0000);
    wr(3'h1, 16'h01ff);
    rd(3'h1, 16'h01ff);
    $display("test reset done");
    i_dausc_seq.flagOp(1'b0, 36'h800000000, 1'b1, 1'b0);
    rd(3'h0, 16'ha000);
    i_dausc_seq.flagOp(1'b1, 36'h000000000, 1'b0, 1'b1);
    rd(3'h0, 16'h5000);
    $display("test flags done");
    wr(3'h1, 16'h0000);
    i_dausc_seq.load(3'h4, 16'h0010);
    i_dausc_seq.load(3'h2, 16'h0008);
    #1 `CHK(yReg, 32'h00080000)
    for (int k = 0; k < 4; k++) begin
      wr(3'h1, k[15:0]);
      i_dausc_seq.prodLoad(k == 1);
      #1 `CHK(k == 1 ? acc1 : acc0, alExp[k])
    end
    `CHK(prod, 32'h00000080)
    $display("test align done");
    wr(3'h1, 16'h0008);
    i_dausc_seq.sumLoad(1'b0, 37'h1f7fffffff);
    #1 `CHK(acc0, 36'hf80000000)
    i_dausc_seq.sumLoad(1'b1, 37'h1f7fffffff);
    #1 `CHK(acc1, 36'hf7fffffff)
    rd(3'h0, 16'h53ff);
    `CHK(irq, 1'b0)
    wr(3'h3, 16'h000f);
    #1 `CHK(irq, 1'b1)
    rd(3'h2, 16'h0007);
    `CHK(irq, 1'b0)
    $display("test overflow done");
    wr(3'h1, 16'h0080);
    i_dausc_seq.load(3'h2, 16'h1234);
    #1 `CHK(xReg, 16'h1234)
    wr(3'h1, 16'h0040);
    i_dausc_seq.load(3'h1, 16'h5678);
    i_dausc_seq.load(3'h2, 16'habcd);
    #1 `CHK(yReg, 32'habcd5678)
    `CHK(xReg, 16'h1234)
    i_dausc_seq.hiLoad(1'b0, 16'h8001);
    #1 `CHK(acc0, 36'hf80010000)
    wr(3'h1, 16'h0020);
    i_dausc_seq.hiLoad(1'b1, 16'h0123);
    #1 `CHK(acc1, 36'h00123ffff)
    wr(3'h0, 16'hfc00);
    rd(3'h0, 16'hf000);
    $display("test operands done");
    i_dausc_seq.pseudorandom_generator(1'b0, 1'b0);
    wr(3'h1, 16'h0000);
    i_dausc_seq.pseudorandom_generator(1'b1, 1'b1);
    #1 `CHK(psgOut, 16'h0002)
    i_dausc_seq.pseudorandom_generator(1'b1, 1'b0);
    #1 `CHK(psgOut, 16'h0001)
    i_dausc_seq.pseudorandom_generator(1'b0, 1'b0);
    wr(3'h1, 16'h0100);
    i_dausc_seq.pseudorandom_generator(1'b1, 1'b0);
    #1 `CHK(psgOut, 16'h0002)
    rd(3'h2, 16'h0008);
    `CHK(irq, 1'b0)
    $display("test generator done");
    testDone;
  end
endmodule
bind dausc_top dausc_sva i_dausc_sva (
  .clk(clk), .sys_rst(sys_rst), .regWr(regWr), .regRd(regRd),
  .dauFlagWr(dauFlagWr), .bmuFlagWr(bmuFlagWr), .bmuLlv(bmuLlv),
  .bmuLmv(bmuLmv), .a0SumLd(a0SumLd), .a1SumLd(a1SumLd),
  .a1ProdLd(a1ProdLd), .yHiLd(yHiLd), .piWr(piWr), .inIsr(inIsr),
  .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
  .yData(yData), .xReg(xReg), .psgOut(psgOut), .dauResult(dauResult),
  .acc0(acc0), .acc1(acc1), .sum(sum), .prod(prod), .yReg(yReg)
);
